//--- pkg/hdsc_pkg.sv
// constants, carrier structs, state enums and check-word arithmetic for the
// half-duplex block serial controller; assumes a 50 mhz system clock
package hdsc_pkg;

  localparam int WORD_W = 12;
  localparam int CLK_NS = 20;

  // register offsets on the plain register port
  localparam logic [3:0] OFF_CMD = 4'h0;
  localparam logic [3:0] OFF_TXD = 4'h4;
  localparam logic [3:0] OFF_RXD = 4'h8;
  localparam logic [3:0] OFF_STAT = 4'hc;

  // command word fields
  localparam int CMD_EQ_HI = 11;
  localparam int CMD_EQ_LO = 9;
  localparam int CMD_CLR_BIT = 3;
  localparam int CMD_END_BIT = 2;

  // status word bit positions
  localparam int ST_NEED = 0;
  localparam int ST_RXRDY = 1;
  localparam int ST_CHKERR = 2;
  localparam int ST_INTR = 3;
  localparam int ST_RESP = 4;
  localparam int ST_TXIND = 5;
  localparam int ST_RXIND = 6;
  localparam int ST_SYNCED = 7;
  localparam int ST_ILOCK = 8;
  localparam int ST_CARR = 9;
  localparam int ST_CTS = 10;

  // fixed transmit test words, sent msb first
  localparam logic [11:0] TEST_WORD1 = 12'h000;
  localparam logic [11:0] TEST_WORD2 = 12'hfff;
  localparam logic [11:0] TEST_WORD3 = 12'h06d;
  localparam logic [11:0] TEST_WORD4 = 12'hf92;

  // default sync, interrupt code and check polynomial (x^12+x^11+x^3+x^2+x+1)
  localparam logic [11:0] SYNC_DEF = 12'h7e1;
  localparam logic [11:0] INTR_DEF = 12'h5a5;
  localparam logic [11:0] POLY_DEF = 12'h80f;

  // momentary error lamp time
  localparam int ERR_SHOW_NS = 50000;
  localparam int ERR_SHOW_CYC = ERR_SHOW_NS / CLK_NS;

  typedef logic [11:0] hdsc_word_t;
  typedef enum logic [1:0] {MODE_IDLE, MODE_TX, MODE_RX} hdsc_mode_e;
  typedef enum logic [1:0] {RXT_OFF, RXT_REC, RXT_INT} hdsc_rxtest_e;
  typedef enum logic [1:0] {TX_OFF, TX_SYNC, TX_DATA, TX_CHECK} hdsc_tx_e;
  typedef enum logic [1:0] {RX_HUNT, RX_DATA} hdsc_rx_e;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    hdsc_word_t wdata;
    logic wr;
    logic rd;
  } hdsc_bus_s;

  // data set pins toward the controller
  typedef struct packed {
    logic tx_clk;
    logic rx_clk;
    logic rx_data;
    logic response_in;
    logic clear_to_send;
    logic interlock;
    logic carrier;
  } hdsc_line_s;

  // one check step per bit, msb first
  function automatic hdsc_word_t crc_word(input hdsc_word_t crc, input hdsc_word_t w, input hdsc_word_t poly);
    hdsc_word_t c;
    logic fb;
    c = crc;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      fb = w[i] ^ c[11];
      c = {c[10:0], 1'b0} ^ (fb ? poly : 12'h000);
    end
    return c;
  endfunction : crc_word

endpackage : hdsc_pkg

//--- design/hdsc_sync.sv
// two-flop synchroniser with edge detection for a bundle of pins
// assumes the inputs are asynchronous to clk
`timescale 1ns/1ps
module hdsc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  import hdsc_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } hdsc_sync_s;

  hdsc_sync_s st_r;
  hdsc_sync_s st_nxt;

  // s1 only feeds s2; edges come from s2 against s3
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lvl = st_r.s2;
  assign rise = st_r.s2 & ~st_r.s3;
  assign fall = st_r.s3 & ~st_r.s2;

endmodule : hdsc_sync

//--- design/hdsc_stretch.sv
// stretches a one-cycle pulse into a visible indication
// assumes a registered input pulse; a new pulse restarts the time
`timescale 1ns/1ps
module hdsc_stretch #(
  parameter int CYC = 2500
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pulse,
  output logic show
);
  import hdsc_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic show;
  } hdsc_str_s;

  hdsc_str_s st_r;
  hdsc_str_s st_nxt;

  // count down while lit
  always_comb begin
    st_nxt = st_r;
    if (pulse) begin
      st_nxt.cnt = 16'(CYC - 1);
      st_nxt.show = 1'b1;
    end else if (st_r.cnt != 16'h0000) begin
      st_nxt.cnt = st_r.cnt - 16'h0001;
    end else begin
      st_nxt.show = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign show = st_r.show;

endmodule : hdsc_stretch

//--- design/hdsc_ctrl.sv
// half-duplex block serial controller: one serial line controller
// assumes the data set supplies both bit clocks, far slower than CLOCK,
// and that software drives the plain register port synchronously
`timescale 1ns/1ps
module hdsc_ctrl #(
  parameter hdsc_pkg::hdsc_word_t SYNC_WORD = hdsc_pkg::SYNC_DEF,
  parameter hdsc_pkg::hdsc_word_t INTR_WORD = hdsc_pkg::INTR_DEF,
  parameter hdsc_pkg::hdsc_word_t POLY = hdsc_pkg::POLY_DEF,
  parameter int ERR_CYC = hdsc_pkg::ERR_SHOW_CYC
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire hdsc_pkg::hdsc_bus_s BUS,
  output hdsc_pkg::hdsc_word_t RDATA,
  input wire hdsc_pkg::hdsc_line_s LINE,
  output logic SEND_LINE,
  output logic SEND_REQUEST,
  output logic RESPONSE_OUT,
  output logic TX_IND,
  output logic RX_IND,
  output logic ERROR_IND,
  input wire logic CLEAR_N,
  input wire logic [2:0] TX_TEST,
  input wire logic [1:0] RX_TEST,
  input wire logic [2:0] EQUIP
);
  import hdsc_pkg::*;

  localparam int PIN_W = 7 + 9;

  typedef struct packed {
    hdsc_mode_e mode;
    logic end_blk;
    hdsc_word_t tx_word;
    logic tx_full;
    hdsc_tx_e tst;
    hdsc_word_t tsh;
    logic [3:0] tcnt;
    hdsc_word_t tcrc;
    logic test_sent;
    logic send;
    hdsc_rx_e rst;
    hdsc_word_t rsh;
    logic [3:0] rcnt;
    hdsc_word_t rcrc;
    hdsc_word_t rx_word;
    logic rx_full;
    logic chk_err;
    logic intr_ff;
    logic resp_seen;
    logic resp_out;
    logic err_pulse;
    hdsc_word_t rdata;
    logic tx_ind;
    logic rx_ind;
    logic send_req;
  } hdsc_ctrl_s;

  hdsc_ctrl_s st_r;
  hdsc_ctrl_s st_nxt;

  logic [PIN_W-1:0] pin_lvl;
  logic [PIN_W-1:0] pin_rise;
  logic [PIN_W-1:0] pin_fall;
  logic err_show;

  // every pin and switch passes two flops before use
  hdsc_sync #(
    .W(PIN_W)
  ) u_sync (
    .clk(CLOCK),
    .rst_n(RST_N),
    .d({LINE, CLEAR_N, TX_TEST, RX_TEST, EQUIP}),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  hdsc_line_s line_q;
  logic clear_q;
  logic [2:0] txt_q;
  hdsc_rxtest_e rxt_q;
  logic [2:0] equip_q;
  logic txc_rise;
  logic rxc_fall;

  assign line_q = pin_lvl[15:9];
  assign clear_q = ~pin_lvl[8];
  assign txt_q = pin_lvl[7:5];
  assign rxt_q = hdsc_rxtest_e'(pin_lvl[4:3]);
  assign equip_q = pin_lvl[2:0];
  assign txc_rise = pin_rise[15];
  assign rxc_fall = pin_fall[14];

  // the lamp is stretched so a single-cycle mismatch can be seen
  hdsc_stretch #(
    .CYC(ERR_CYC)
  ) u_err (
    .clk(CLOCK),
    .rst_n(RST_N),
    .pulse(st_r.err_pulse),
    .show(err_show)
  );

  // pick the fixed test word for the switch position
  function automatic hdsc_word_t test_word(input logic [2:0] pos);
    unique case (pos)
      3'h1: test_word = TEST_WORD1;
      3'h2: test_word = TEST_WORD2;
      3'h3: test_word = TEST_WORD3;
      default: test_word = TEST_WORD4;
    endcase
  endfunction : test_word

  logic tx_test;
  logic tx_act;
  logic rx_act;
  logic rx_test;
  hdsc_word_t rnew;
  hdsc_word_t nxt_word;
  hdsc_word_t stat;

  // direction decode: a test transmit overrides every receive path
  assign tx_test = (txt_q != 3'h0) && (txt_q <= 3'h4);
  assign tx_act = (st_r.mode == MODE_TX) || tx_test;
  assign rx_test = (rxt_q == RXT_REC) && !tx_act;
  assign rx_act = ((st_r.mode == MODE_RX) && !tx_test) || rx_test;
  assign rnew = {st_r.rsh[10:0], line_q.rx_data};

  // status word assembly
  always_comb begin
    stat = '0;
    stat[ST_NEED] = (st_r.mode == MODE_TX) && !st_r.tx_full;
    stat[ST_RXRDY] = st_r.rx_full;
    stat[ST_CHKERR] = st_r.chk_err;
    stat[ST_INTR] = st_r.intr_ff;
    stat[ST_RESP] = st_r.resp_seen;
    stat[ST_TXIND] = st_r.tx_ind;
    stat[ST_RXIND] = st_r.rx_ind;
    stat[ST_SYNCED] = (st_r.rst == RX_DATA);
    stat[ST_ILOCK] = line_q.interlock;
    stat[ST_CARR] = line_q.carrier;
    stat[ST_CTS] = line_q.clear_to_send;
  end

  // next state: bus first, then line events, so hardware sets win over clears
  always_comb begin
    st_nxt = st_r;
    nxt_word = '0;
    st_nxt.err_pulse = 1'b0;
    st_nxt.rdata = '0;

    // register writes
    if (BUS.wr && BUS.addr == OFF_CMD && BUS.wdata[CMD_EQ_HI:CMD_EQ_LO] == equip_q) begin
      if (BUS.wdata[1:0] <= 2'h2) begin
        st_nxt.mode = hdsc_mode_e'(BUS.wdata[1:0]);
      end
      st_nxt.end_blk = BUS.wdata[CMD_END_BIT];
      if (BUS.wdata[CMD_CLR_BIT]) begin
        st_nxt.chk_err = 1'b0;
        st_nxt.intr_ff = 1'b0;
        st_nxt.resp_seen = 1'b0;
      end
    end
    if (BUS.wr && BUS.addr == OFF_TXD) begin
      st_nxt.tx_word = BUS.wdata;
      st_nxt.tx_full = 1'b1;
    end

    // register reads, answered in the following cycle
    if (BUS.rd) begin
      unique case (BUS.addr)
        OFF_CMD: st_nxt.rdata = {equip_q, 6'h00, st_r.end_blk, st_r.mode};
        OFF_TXD: st_nxt.rdata = st_r.tx_word;
        OFF_RXD: begin
          st_nxt.rdata = st_r.rx_word;
          st_nxt.rx_full = 1'b0;
        end
        OFF_STAT: st_nxt.rdata = stat;
        default: st_nxt.rdata = '0;
      endcase
    end

    // remote answer to our sync, caught only while transmitting
    if (line_q.response_in && tx_act) begin
      st_nxt.resp_seen = 1'b1;
    end

    // transmit: change the bit on clock rise so it is steady at the fall
    if (!tx_act || !line_q.clear_to_send) begin
      st_nxt.tst = TX_OFF;
      st_nxt.tcnt = 4'h0;
      st_nxt.send = 1'b0;
      st_nxt.test_sent = 1'b0;
    end else if (txc_rise) begin
      if (st_r.tcnt != 4'h0) begin
        nxt_word = st_r.tsh;
        st_nxt.tcnt = st_r.tcnt - 4'h1;
      end else begin
        st_nxt.tcnt = 4'(WORD_W - 1);
        unique case (st_r.tst)
          TX_OFF, TX_CHECK: begin
            nxt_word = SYNC_WORD;
            st_nxt.tst = TX_SYNC;
            st_nxt.tcrc = '0;
            st_nxt.test_sent = 1'b0;
          end
          TX_SYNC, TX_DATA: begin
            if (tx_test && !st_r.test_sent) begin
              nxt_word = test_word(txt_q);
              st_nxt.tst = TX_DATA;
              st_nxt.test_sent = 1'b1;
              st_nxt.tcrc = crc_word(st_r.tcrc, nxt_word, POLY);
            end else if (tx_test) begin
              nxt_word = st_r.tcrc;
              st_nxt.tst = TX_CHECK;
            end else if (st_r.tx_full) begin
              nxt_word = st_r.tx_word;
              // a host word written in this very cycle must not be lost
              st_nxt.tx_full = BUS.wr && (BUS.addr == OFF_TXD);
              st_nxt.tst = TX_DATA;
              st_nxt.tcrc = crc_word(st_r.tcrc, nxt_word, POLY);
            end else if (st_r.end_blk && st_r.tst == TX_DATA) begin
              nxt_word = st_r.tcrc;
              st_nxt.tst = TX_CHECK;
              st_nxt.end_blk = 1'b0;
            end else begin
              nxt_word = SYNC_WORD;
              st_nxt.tst = TX_SYNC;
            end
          end
        endcase
      end
      st_nxt.send = nxt_word[11];
      st_nxt.tsh = {nxt_word[10:0], 1'b0};
    end

    // receive: sample on the falling edge of the receive clock
    if (!rx_act) begin
      st_nxt.rst = RX_HUNT;
      st_nxt.rcnt = 4'h0;
      st_nxt.resp_out = 1'b0;
    end
    if (rxc_fall) begin
      st_nxt.rsh = rnew;
      if (!rx_act && !tx_act && rnew == INTR_WORD) begin
        st_nxt.intr_ff = 1'b1;
      end
      if (rx_act && st_r.rst == RX_HUNT && rnew == SYNC_WORD) begin
        st_nxt.rst = RX_DATA;
        st_nxt.rcnt = 4'h0;
        st_nxt.rcrc = '0;
        st_nxt.resp_out = 1'b1;
      end else if (rx_act && st_r.rst == RX_DATA) begin
        st_nxt.rcnt = st_r.rcnt + 4'h1;
        if (st_r.rcnt == 4'(WORD_W - 1)) begin
          st_nxt.rcnt = 4'h0;
          if (rnew == SYNC_WORD && st_r.rcrc == '0) begin
            st_nxt.rst = RX_DATA; // fill between sync and first word
          end else if (rx_test && st_r.rcrc != '0 || !rx_test && st_r.end_blk) begin
            if (rnew != st_r.rcrc) begin
              st_nxt.chk_err = 1'b1;
              st_nxt.err_pulse = 1'b1;
            end
            st_nxt.rst = RX_HUNT;
            st_nxt.resp_out = 1'b0;
            st_nxt.end_blk = 1'b0;
          end else begin
            st_nxt.rcrc = crc_word(st_r.rcrc, rnew, POLY);
            if (!rx_test) begin
              st_nxt.rx_word = rnew;
              st_nxt.rx_full = 1'b1;
            end
          end
        end
      end
    end

    // indications and send request follow the direction
    st_nxt.tx_ind = tx_act;
    st_nxt.rx_ind = rx_act;
    st_nxt.send_req = tx_act;

    // manual clear drops everything back to idle
    if (clear_q) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RDATA = st_r.rdata;
  assign SEND_LINE = st_r.send;
  assign SEND_REQUEST = st_r.send_req;
  assign RESPONSE_OUT = st_r.resp_out;
  assign TX_IND = st_r.tx_ind;
  assign RX_IND = st_r.rx_ind;
  assign ERROR_IND = err_show;

endmodule : hdsc_ctrl

//--- tb/hdsc_ctrl_checker.sv
// port assertions for the block serial controller
// bound into every hdsc_ctrl; sees only its ports
`timescale 1ns/1ps
module hdsc_ctrl_checker #(
  parameter int ERR_CYC = 4
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire hdsc_pkg::hdsc_bus_s BUS,
  input wire hdsc_pkg::hdsc_word_t RDATA,
  input wire hdsc_pkg::hdsc_line_s LINE,
  input wire logic SEND_LINE,
  input wire logic SEND_REQUEST,
  input wire logic RESPONSE_OUT,
  input wire logic TX_IND,
  input wire logic RX_IND,
  input wire logic ERROR_IND,
  input wire logic CLEAR_N,
  input wire logic [2:0] TX_TEST,
  input wire logic [1:0] RX_TEST,
  input wire logic [2:0] EQUIP
);
  import hdsc_pkg::*;
  default clocking dc @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  int err_len_r;
  // cycles the error lamp has been lit so far
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) err_len_r <= 0;
    else err_len_r <= ERROR_IND ? err_len_r + 1 : 0;
  end
  AST_ONE_WAY: assert property (!(TX_IND && RX_IND) && !(SEND_REQUEST && RX_IND))
    else $error("sending and receiving at once");
  AST_TX_REQ: assert property (TX_IND |-> SEND_REQUEST || $past(SEND_REQUEST))
    else $error("transmit lamp without send request");
  AST_RD_LATE: assert property (!$past(BUS.rd) |-> RDATA == 12'h000)
    else $error("read data outside its cycle");
  AST_ERR_LEN: assert property ($fell(ERROR_IND) |-> err_len_r + 1 >= ERR_CYC)
    else $error("error lamp too short");
  AST_ERR_CAUSE: assert property ($rose(ERROR_IND) |-> RX_IND || RX_TEST != 2'h0)
    else $error("error lamp outside receive");
  AST_RESP_DIR: assert property (RESPONSE_OUT |-> !SEND_REQUEST)
    else $error("response while sending");
  AST_RESP_RX: assert property ($rose(RESPONSE_OUT) |-> RX_IND || RX_TEST != 2'h0)
    else $error("response outside receive");
  AST_SEND_HOLD: assert property (SEND_REQUEST && $fell(LINE.tx_clk) ##1 SEND_REQUEST |-> $stable(SEND_LINE))
    else $error("send bit moved near sampling edge");
  AST_CLEAR: assert property ($fell(CLEAR_N) |-> ##[1:4] !(TX_IND || RX_IND || SEND_REQUEST || RESPONSE_OUT))
    else $error("manual clear left controller busy");
  AST_EQUIP: assert property (
    BUS.wr && !$past(BUS.wr) && BUS.addr == OFF_CMD && BUS.wdata[11:9] != EQUIP && !TX_IND && !RX_IND
    && TX_TEST == 3'h0 && RX_TEST == 2'h0 ##1 (!BUS.wr) [*3] |-> !TX_IND && !RX_IND)
    else $error("foreign command obeyed");
  cover property ($rose(ERROR_IND));
  cover property ($rose(RESPONSE_OUT));
  cover property (SEND_REQUEST && $fell(LINE.tx_clk));
endmodule : hdsc_ctrl_checker

bind hdsc_ctrl hdsc_ctrl_checker #(.ERR_CYC(ERR_CYC)) chk_u (.CLOCK(CLOCK), .RST_N(RST_N), .BUS(BUS),
  .RDATA(RDATA), .LINE(LINE), .SEND_LINE(SEND_LINE), .SEND_REQUEST(SEND_REQUEST), .RESPONSE_OUT(RESPONSE_OUT),
  .TX_IND(TX_IND), .RX_IND(RX_IND), .ERROR_IND(ERROR_IND), .CLEAR_N(CLEAR_N), .TX_TEST(TX_TEST),
  .RX_TEST(RX_TEST), .EQUIP(EQUIP));

//--- tb/hdsc_dataset.sv
// behavioural data set facing the controller's line pins
// bit clocks run only in frames, 160 ns period, off the system clock grid
`timescale 1ns/1ps
module hdsc_dataset (
  input wire logic SEND_LINE,
  input wire logic SEND_REQUEST,
  output hdsc_pkg::hdsc_line_s LINE
);
  import hdsc_pkg::*;
  logic tc = 1'b0;
  logic rc = 1'b0;
  logic rd = 1'b0;
  logic resp = 1'b0;
  hdsc_word_t sh;
  logic q[$];
  // clear to send simply follows the request; interlock and carrier stay on
  assign LINE = {tc, rc, rd, resp, SEND_REQUEST, 2'b11};
  // transmit clock only while asked to send; we are the receiving end then
  always begin
    wait (SEND_REQUEST === 1'b1);
    #47 tc = 1'b1;
    #80 tc = 1'b0;
    #33;
  end
  // sample the send line on the falling transmit clock, answer a sync word
  always @(negedge tc) begin
    q.push_back(SEND_LINE);
    sh = {sh[10:0], SEND_LINE};
    if (sh === SYNC_DEF) resp = 1'b1;
  end
  // each start or end of a frame begins capture afresh
  always @(SEND_REQUEST) begin
    q.delete();
    sh = 12'h000;
    resp = 1'b0;
  end
  // one word toward the controller, msb first, data moves on the rising clock
  task automatic send_word(input hdsc_word_t w);
    #7;
    for (int i = 11; i >= 0; i--) begin
      rc = 1'b1;
      rd = w[i];
      #80 rc = 1'b0;
      #80;
    end
    rd = ~rd; // released line must not keep showing the last bit
  endtask : send_word
endmodule : hdsc_dataset

//--- tb/hdsc_ctrl_tb.sv
// self-checking bench: register port tasks, data set model, block scenarios
// drives inputs on rising clk by non-blocking assignment
`timescale 1ns/1ps
module hdsc_ctrl_tb;
  import hdsc_pkg::*;
  localparam logic [2:0] EQ = 3'h5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clear_n = 1'b1;
  logic [2:0] tx_test = 3'h0;
  logic [1:0] rx_test = 2'h0;
  hdsc_bus_s bus = '0;
  hdsc_line_s line;
  hdsc_word_t rdata, v;
  logic send_line, send_req, resp_out, tx_ind, rx_ind, err_ind;
  hdsc_word_t tw [4] = '{12'h000, 12'hfff, 12'h06d, 12'hf92};
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;

  hdsc_ctrl #(.ERR_CYC(4)) dut_u (.CLOCK(clk), .RST_N(rst_n), .BUS(bus), .RDATA(rdata), .LINE(line),
    .SEND_LINE(send_line), .SEND_REQUEST(send_req), .RESPONSE_OUT(resp_out), .TX_IND(tx_ind),
    .RX_IND(rx_ind), .ERROR_IND(err_ind), .CLEAR_N(clear_n), .TX_TEST(tx_test), .RX_TEST(rx_test), .EQUIP(EQ));
  hdsc_dataset ds_u (.SEND_LINE(send_line), .SEND_REQUEST(send_req), .LINE(line));

  // 50 mhz system clock
  always #10 clk = ~clk;

  task automatic check(input hdsc_word_t seen, input hdsc_word_t exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic reg_wr(input logic [3:0] a, input hdsc_word_t d);
    @(posedge clk);
    bus <= {a, d, 2'b10};
    @(posedge clk);
    bus <= '0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk);
    bus <= {a, 12'h000, 2'b01};
    @(posedge clk);
    bus <= '0;
    #1 v = rdata;
  endtask : reg_rd

  function automatic hdsc_word_t cmd(input logic last, input logic [1:0] mode);
    return {EQ, 6'h00, last, mode};
  endfunction : cmd

  // bench's own check word, msb first, zero start
  function automatic hdsc_word_t chk(input hdsc_word_t w);
    hdsc_word_t c = 12'h000;
    for (int i = 11; i >= 0; i--) c = {c[10:0], 1'b0} ^ ((w[i] ^ c[11]) ? POLY_DEF : 12'h000);
    return c;
  endfunction : chk

  // wait for three words on the send line: sync, the data word, its check
  task automatic frame_check(input hdsc_word_t w);
    hdsc_word_t f;
    int n = 0;
    while (ds_u.q.size() < 36 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 12; i++) f = {f[10:0], ds_u.q[12 * k + i]};
      check(f, k == 0 ? SYNC_DEF : k == 1 ? w : chk(w));
    end
  endtask : frame_check

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // foreign equipment number is ignored; an unmapped place reads zero
    reg_wr(OFF_CMD, {3'h2, 9'h001});
    reg_rd(OFF_CMD);
    check(v, 12'ha00);
    reg_rd(4'h2);
    check(v, 12'h000);
    // one transmitted block, end marked early so the check follows the word
    reg_wr(OFF_CMD, cmd(1'b0, 2'h1));
    reg_rd(OFF_STAT);
    check({v[ST_RXIND], v[ST_TXIND], v[ST_NEED]}, 12'h003);
    check(send_req, 1'b1);
    reg_wr(OFF_TXD, 12'h4c3);
    reg_wr(OFF_CMD, cmd(1'b1, 2'h1));
    frame_check(12'h4c3);
    reg_rd(OFF_STAT);
    check(v[ST_RESP], 1'b1);
    reg_wr(OFF_CMD, cmd(1'b0, 2'h0));
    // every transmit test position
    for (int t = 1; t <= 4; t++) begin
      repeat (20) @(posedge clk);
      tx_test <= t[2:0];
      frame_check(tw[t - 1]);
      tx_test <= 3'h0;
    end
    // receive: sync brings a response, word offered, bad check flagged
    repeat (20) @(posedge clk);
    reg_wr(OFF_CMD, cmd(1'b0, 2'h2));
    ds_u.send_word(SYNC_DEF);
    repeat (5) @(posedge clk);
    check(resp_out, 1'b1);
    ds_u.send_word(12'h35a);
    repeat (5) @(posedge clk);
    reg_rd(OFF_STAT);
    check({v[ST_RXIND], v[ST_TXIND], v[ST_RXRDY]}, 12'h005);
    reg_rd(OFF_RXD);
    check(v, 12'h35a);
    reg_wr(OFF_CMD, cmd(1'b1, 2'h2));
    ds_u.send_word(chk(12'h35a) ^ 12'h001);
    @(posedge clk);
    #1 check(err_ind, 1'b1);
    repeat (5) @(posedge clk);
    reg_rd(OFF_STAT);
    check({v[ST_RXRDY], v[ST_CHKERR]}, 12'h001);
    // receive test: a good one-word block passes, a bad one is flagged
    for (int b = 0; b < 2; b++) begin
      reg_wr(OFF_CMD, 12'h008 | cmd(1'b0, 2'h0));
      rx_test <= 2'h1;
      ds_u.send_word(SYNC_DEF);
      ds_u.send_word(12'h0f0);
      ds_u.send_word(chk(12'h0f0) ^ {b[0], 11'h000});
      repeat (5) @(posedge clk);
      reg_rd(OFF_STAT);
      check(v[ST_CHKERR], b[0]);
    end
    // interrupt word taken while idle, interrupt test position selected
    rx_test <= 2'h2;
    ds_u.send_word(INTR_DEF);
    repeat (5) @(posedge clk);
    reg_rd(OFF_STAT);
    check(v[ST_INTR], 1'b1);
    // manual clear right after transmit mode is selected, before the first bit is sent
    reg_wr(OFF_CMD, cmd(1'b0, 2'h1));
    clear_n <= 1'b0;
    repeat (4) @(posedge clk);
    clear_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(tx_ind, 1'b0);
    reg_rd(OFF_CMD);
    check(v, 12'ha00);
    wrap_up();
  end
endmodule : hdsc_ctrl_tb
